// File: core/ucrd_decode.sv
// Register decode for both channels of the dual serial port
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Each channel owns a register set, chosen by its chip select and three address lines.
// - Divisor bit clear: address 0 reads receive holding, writes go to transmit holding.
// - Divisor bit set, not key: addresses 0 and 1 access divisor low and high.
// - Divisor zero, divisor bit set, not key: reads 0,1 give revision and id codes.
// - Divisor bit clear: address 1 accesses interrupt enable.
// - Not key: address 2 reads interrupt status, writes FIFO control.
// - Address 3 always accesses line control.
// - Not key: address 4 accesses modem control.
// - Not key: address 5 reads line status, address 6 modem status, both read-only.
// - Not key, feature bit 6 clear: address 7 is scratchpad.
// - Not key, feature bit 6 set: address 7 reads FIFO level, writes mode select.
// - Key: address 0 writes trigger level, reads FIFO level count.
// - Key: address 1 accesses feature control, address 2 enhanced function.
// - Key: addresses 4 to 7 access Xon1, Xon2, Xoff1, Xoff2.
// - Enhanced bits take writes and read back only while enhanced-function bit 4 is one.
module ucrd_decode #(
    parameter int         NUM_CH        = 2,
    parameter logic [7:0] REVISION_CODE = 8'h01,  // Arbitrary value
    parameter logic [7:0] DEVICE_ID     = 8'h5A   // Arbitrary value
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  channel_a_select_n,
    input  wire logic                  channel_b_select_n,
    input  wire ucrd_pkg::ucrd_acc_t   acc,
    input  wire ucrd_pkg::ucrd_stat_t  stat_a,
    input  wire ucrd_pkg::ucrd_stat_t  stat_b,
    output logic [7:0]                 rdata,
    output logic                       rdata_valid,
    output ucrd_pkg::ucrd_cfg_t        cfg_a,
    output ucrd_pkg::ucrd_cfg_t        cfg_b,
    output logic [1:0]                 tx_holding_wr,
    output logic [7:0]                 tx_holding,
    output logic [1:0]                 rx_holding_rd,
    output logic [1:0]                 line_status_rd,
    output logic [1:0]                 modem_status_rd,
    output logic [1:0]                 interrupt_status_rd
);

    initial begin
        if (NUM_CH != 2) begin
            $error("ucrd_decode serves exactly two channels");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bank selection

    // Which physical register an address reaches under the current bank state
    function automatic ucrd_pkg::ucrd_sel_t sel_of(input logic [2:0] a, input ucrd_pkg::ucrd_cfg_t c);
        logic key;
        key = (c.line_control == ucrd_pkg::ENH_KEY);
        sel_of = ucrd_pkg::UCRD_OTHER;
        if (a == ucrd_pkg::ADDR_HOLD) begin
            if (key) sel_of = ucrd_pkg::UCRD_TRG;
            else if (c.line_control[ucrd_pkg::LC_DIV_BIT]) sel_of = ucrd_pkg::UCRD_DIVL;
            else sel_of = ucrd_pkg::UCRD_HOLD;
        end else if (a == ucrd_pkg::ADDR_IE) begin
            if (key) sel_of = ucrd_pkg::UCRD_OTHER;
            else if (c.line_control[ucrd_pkg::LC_DIV_BIT]) sel_of = ucrd_pkg::UCRD_DIVH;
            else sel_of = ucrd_pkg::UCRD_IE;
        end else if (a == ucrd_pkg::ADDR_ISFC && !key) begin
            sel_of = ucrd_pkg::UCRD_ISFC;
        end
    endfunction

    logic [1:0]          sel;
    ucrd_pkg::ucrd_cfg_t cfg [2];
    logic                any_rd;
    logic [7:0]          next_rdata;
    logic [1:0]          is_rd_hold;
    logic [1:0]          is_rd_ls;
    logic [1:0]          is_rd_ms;
    logic [1:0]          is_rd_is;
    logic [1:0]          is_wr_hold;

    assign sel    = {~channel_b_select_n, ~channel_a_select_n};
    assign any_rd = acc.rd && (sel != 2'b00);
    assign cfg_a  = cfg[0];
    assign cfg_b  = cfg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Register sets, one per channel

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        ucrd_pkg::ucrd_sel_t s;
        logic                key;
        logic                swap;
        logic                we;
        logic                enh;
        assign s    = sel_of(acc.addr, cfg[ch]);
        assign key  = (cfg[ch].line_control == ucrd_pkg::ENH_KEY);
        assign swap = cfg[ch].feature_control[ucrd_pkg::FCT_SWAP];
        assign we   = acc.wr && sel[ch];
        assign enh  = cfg[ch].enhanced_function[ucrd_pkg::EF_ENH_BIT];

        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                cfg[ch] <= '0;
            end else if (we) begin
                unique case (s)
                    ucrd_pkg::UCRD_DIVL: cfg[ch].divisor_low <= acc.wdata;
                    ucrd_pkg::UCRD_DIVH: cfg[ch].divisor_high <= acc.wdata;
                    ucrd_pkg::UCRD_IE: begin
                        cfg[ch].interrupt_enable <= enh ? acc.wdata
                                                        : (acc.wdata & ~ucrd_pkg::IE_ENH_MASK);
                    end
                    ucrd_pkg::UCRD_ISFC: begin
                        cfg[ch].fifo_control <= enh ? acc.wdata
                                                    : (acc.wdata & ~ucrd_pkg::FC_ENH_MASK);
                    end
                    ucrd_pkg::UCRD_TRG: cfg[ch].fifo_trigger_level <= acc.wdata;
                    ucrd_pkg::UCRD_HOLD: ;
                    ucrd_pkg::UCRD_NONE: ;
                    ucrd_pkg::UCRD_OTHER: begin
                        unique case (acc.addr)
                            ucrd_pkg::ADDR_IE: cfg[ch].feature_control <= acc.wdata;
                            ucrd_pkg::ADDR_ISFC: cfg[ch].enhanced_function <= acc.wdata;
                            ucrd_pkg::ADDR_LC: cfg[ch].line_control <= acc.wdata;
                            ucrd_pkg::ADDR_MC: begin
                                if (key) cfg[ch].xon_char_1 <= acc.wdata;
                                else cfg[ch].modem_control <= enh ? acc.wdata
                                                            : (acc.wdata & ~ucrd_pkg::MC_ENH_MASK);
                            end
                            ucrd_pkg::ADDR_LS: if (key) cfg[ch].xon_char_2 <= acc.wdata;
                            ucrd_pkg::ADDR_MS: if (key) cfg[ch].xoff_char_1 <= acc.wdata;
                            ucrd_pkg::ADDR_SP: begin
                                if (key) cfg[ch].xoff_char_2 <= acc.wdata;
                                else if (swap) cfg[ch].enhanced_mode_select <= acc.wdata;
                                else cfg[ch].scratchpad <= acc.wdata;
                            end
                            default: ;
                        endcase
                    end
                endcase
            end
        end

        assign is_rd_hold[ch] = acc.rd && sel[ch] && (s == ucrd_pkg::UCRD_HOLD);
        assign is_wr_hold[ch] = we && (s == ucrd_pkg::UCRD_HOLD);
        assign is_rd_is[ch]   = acc.rd && sel[ch] && (s == ucrd_pkg::UCRD_ISFC);
        assign is_rd_ls[ch]   = acc.rd && sel[ch] && !key && (acc.addr == ucrd_pkg::ADDR_LS);
        assign is_rd_ms[ch]   = acc.rd && sel[ch] && !key && (acc.addr == ucrd_pkg::ADDR_MS);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Channel A wins if the host selects both at once
    always_comb begin
        ucrd_pkg::ucrd_cfg_t  c;
        ucrd_pkg::ucrd_stat_t st;
        logic                 key;
        logic                 enh;
        c          = sel[0] ? cfg[0] : cfg[1];
        st         = sel[0] ? stat_a : stat_b;
        key        = (c.line_control == ucrd_pkg::ENH_KEY);
        enh        = c.enhanced_function[ucrd_pkg::EF_ENH_BIT];
        next_rdata = ucrd_pkg::RST_ZERO;
        unique case (sel_of(acc.addr, c))
            ucrd_pkg::UCRD_HOLD: next_rdata = st.rx_holding;
            ucrd_pkg::UCRD_DIVL: begin
                next_rdata = ({c.divisor_high, c.divisor_low} == 16'h0000) ? REVISION_CODE
                                                                          : c.divisor_low;
            end
            ucrd_pkg::UCRD_DIVH: begin
                next_rdata = ({c.divisor_high, c.divisor_low} == 16'h0000) ? DEVICE_ID
                                                                          : c.divisor_high;
            end
            ucrd_pkg::UCRD_IE: begin
                next_rdata = enh ? c.interrupt_enable : (c.interrupt_enable & ~ucrd_pkg::IE_ENH_MASK);
            end
            ucrd_pkg::UCRD_ISFC: begin
                next_rdata = enh ? st.interrupt_status
                                 : (st.interrupt_status & ~ucrd_pkg::IS_ENH_MASK);
            end
            ucrd_pkg::UCRD_TRG: next_rdata = st.fifo_level_count;
            ucrd_pkg::UCRD_NONE: next_rdata = ucrd_pkg::RST_ZERO;
            ucrd_pkg::UCRD_OTHER: begin
                unique case (acc.addr)
                    ucrd_pkg::ADDR_IE: next_rdata = c.feature_control;
                    ucrd_pkg::ADDR_ISFC: next_rdata = c.enhanced_function;
                    ucrd_pkg::ADDR_LC: next_rdata = c.line_control;
                    ucrd_pkg::ADDR_MC: begin
                        next_rdata = key ? c.xon_char_1
                                   : (enh ? c.modem_control : (c.modem_control & ~ucrd_pkg::MC_ENH_MASK));
                    end
                    ucrd_pkg::ADDR_LS: next_rdata = key ? c.xon_char_2 : st.line_status;
                    ucrd_pkg::ADDR_MS: next_rdata = key ? c.xoff_char_1 : st.modem_status;
                    ucrd_pkg::ADDR_SP: begin
                        next_rdata = key ? c.xoff_char_2
                                   : (c.feature_control[ucrd_pkg::FCT_SWAP] ? st.fifo_level_alt
                                                                            : c.scratchpad);
                    end
                    default: next_rdata = ucrd_pkg::RST_ZERO;
                endcase
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata       <= ucrd_pkg::RST_ZERO;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= any_rd;
            if (any_rd) rdata <= next_rdata;
        end
    end

    // Side-effect strobes toward the datapath; one cycle wide, registered, so they come the cycle after the access
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_holding_wr       <= 2'b00;
            tx_holding          <= ucrd_pkg::RST_ZERO;
            rx_holding_rd       <= 2'b00;
            line_status_rd      <= 2'b00;
            modem_status_rd     <= 2'b00;
            interrupt_status_rd <= 2'b00;
        end else begin
            tx_holding_wr <= is_wr_hold;
            // Data only moves on a real holding write, so stray bus traffic never shows here
            if (|is_wr_hold) tx_holding <= acc.wdata;
            rx_holding_rd       <= is_rd_hold;
            line_status_rd      <= is_rd_ls;
            modem_status_rd     <= is_rd_ms;
            interrupt_status_rd <= is_rd_is;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Channel A bank state seen by the checks
    logic a_key;
    logic a_div;
    logic a_enh;
    logic a_swap;
    assign a_key  = g_ch[0].key;
    assign a_div  = cfg[0].line_control[ucrd_pkg::LC_DIV_BIT];
    assign a_enh  = g_ch[0].enh;
    assign a_swap = g_ch[0].swap;

    sequence s_wr_a(logic [2:0] a);
        acc.wr && !channel_a_select_n && acc.addr == a;
    endsequence

    sequence s_rd_a(logic [2:0] a);
        acc.rd && !channel_a_select_n && acc.addr == a;
    endsequence

    sequence s_lc_write;
        acc.wr && !channel_a_select_n && acc.addr == ucrd_pkg::ADDR_LC;
    endsequence

    property p_lc_stores;
        logic [7:0] d;
        @(posedge sys_clk) disable iff (reset) (s_lc_write, d = acc.wdata) |=> cfg[0].line_control == d;
    endproperty

    chk_line_ctrl_store: assert property (p_lc_stores) else $error("line control not stored");

    chk_no_select_hold: assert property (@(posedge sys_clk) disable iff (reset)
        (channel_a_select_n && channel_b_select_n) |=> $stable(cfg[0]) && $stable(cfg[1]) && !rdata_valid)
        else $error("unselected access changed state");

    chk_tx_write_strobe: assert property (@(posedge sys_clk) disable iff (reset)
        (acc.wr && !channel_a_select_n && acc.addr == ucrd_pkg::ADDR_HOLD && !a_div)
        |=> tx_holding_wr[0] && tx_holding == $past(acc.wdata))
        else $error("transmit holding write lost");

    chk_ie_enh_mask: assert property (@(posedge sys_clk) disable iff (reset)
        !a_enh && $changed(cfg[0].interrupt_enable)
        |-> (cfg[0].interrupt_enable & ucrd_pkg::IE_ENH_MASK) == ucrd_pkg::RST_ZERO)
        else $error("enhanced enable bits set while locked");

    chk_div_ident: assert property (@(posedge sys_clk) disable iff (reset)
        (acc.rd && !channel_a_select_n && acc.addr == ucrd_pkg::ADDR_HOLD && a_div && !a_key
         && cfg[0].divisor_low == ucrd_pkg::RST_ZERO && cfg[0].divisor_high == ucrd_pkg::RST_ZERO)
        |=> rdata == REVISION_CODE)
        else $error("revision code not returned");

    chk_ls_read: assert property (@(posedge sys_clk) disable iff (reset)
        (acc.rd && !channel_a_select_n && acc.addr == ucrd_pkg::ADDR_LS && cfg[0].line_control != ucrd_pkg::ENH_KEY)
        |=> rdata == $past(stat_a.line_status) && line_status_rd[0])
        else $error("line status read wrong");

    chk_key_xoff2: assert property (@(posedge sys_clk) disable iff (reset)
        (acc.wr && !channel_b_select_n && channel_a_select_n && acc.addr == ucrd_pkg::ADDR_SP
         && cfg[1].line_control == ucrd_pkg::ENH_KEY)
        |=> cfg[1].xoff_char_2 == $past(acc.wdata) && $stable(cfg[1].scratchpad))
        else $error("xoff2 write misrouted");

    chk_scratch_swap: assert property (@(posedge sys_clk) disable iff (reset)
        (acc.wr && !channel_a_select_n && acc.addr == ucrd_pkg::ADDR_SP && !a_key
         && a_swap) |=> $stable(cfg[0].scratchpad))
        else $error("scratchpad written while swapped");

    chk_rx_hold_read: assert property (@(posedge sys_clk) disable iff (reset)
        s_rd_a(ucrd_pkg::ADDR_HOLD) ##0 !a_div |=> rdata == $past(stat_a.rx_holding) && rx_holding_rd[0])
        else $error("receive holding read wrong");

    chk_div_low_store: assert property (@(posedge sys_clk) disable iff (reset)
        s_wr_a(ucrd_pkg::ADDR_HOLD) ##0 (a_div && !a_key)
        |=> cfg[0].divisor_low == $past(acc.wdata) && !tx_holding_wr[0])
        else $error("divisor low write lost");

    chk_dev_id_read: assert property (@(posedge sys_clk) disable iff (reset)
        s_rd_a(ucrd_pkg::ADDR_IE) ##0 (a_div && !a_key && cfg[0].divisor_low == ucrd_pkg::RST_ZERO
        && cfg[0].divisor_high == ucrd_pkg::RST_ZERO) |=> rdata == DEVICE_ID)
        else $error("device id code not returned");

    chk_ie_store: assert property (@(posedge sys_clk) disable iff (reset)
        s_wr_a(ucrd_pkg::ADDR_IE) ##0 (!a_div && a_enh) |=> cfg[0].interrupt_enable == $past(acc.wdata))
        else $error("interrupt enable write lost");

    chk_fifo_ctrl_mask: assert property (@(posedge sys_clk) disable iff (reset)
        s_wr_a(ucrd_pkg::ADDR_ISFC) ##0 (!a_key && !a_enh)
        |=> cfg[0].fifo_control == ($past(acc.wdata) & ~ucrd_pkg::FC_ENH_MASK))
        else $error("FIFO control enhanced bits not masked");

    chk_mc_store: assert property (@(posedge sys_clk) disable iff (reset)
        s_wr_a(ucrd_pkg::ADDR_MC) ##0 (!a_key && a_enh) |=> cfg[0].modem_control == $past(acc.wdata))
        else $error("modem control write lost");

    chk_ms_read: assert property (@(posedge sys_clk) disable iff (reset)
        s_rd_a(ucrd_pkg::ADDR_MS) ##0 !a_key |=> rdata == $past(stat_a.modem_status) && modem_status_rd[0])
        else $error("modem status read wrong");

    chk_scratch_store: assert property (@(posedge sys_clk) disable iff (reset)
        s_wr_a(ucrd_pkg::ADDR_SP) ##0 (!a_key && !a_swap) |=> cfg[0].scratchpad == $past(acc.wdata))
        else $error("scratchpad write lost");

    chk_trig_store: assert property (@(posedge sys_clk) disable iff (reset)
        s_wr_a(ucrd_pkg::ADDR_HOLD) ##0 a_key |=> cfg[0].fifo_trigger_level == $past(acc.wdata))
        else $error("trigger level write lost");

    chk_feat_store: assert property (@(posedge sys_clk) disable iff (reset)
        s_wr_a(ucrd_pkg::ADDR_IE) ##0 a_key |=> cfg[0].feature_control == $past(acc.wdata))
        else $error("feature control write lost");

endmodule // ucrd_decode

`default_nettype wire

// File: core/ucrd_pkg.sv
// Constants and carrier types for the channel register decode block
package ucrd_pkg;
    localparam logic [2:0] ADDR_HOLD   = 3'h0;
    localparam logic [2:0] ADDR_IE     = 3'h1;
    localparam logic [2:0] ADDR_ISFC   = 3'h2;
    localparam logic [2:0] ADDR_LC     = 3'h3;
    localparam logic [2:0] ADDR_MC     = 3'h4;
    localparam logic [2:0] ADDR_LS     = 3'h5;
    localparam logic [2:0] ADDR_MS     = 3'h6;
    localparam logic [2:0] ADDR_SP     = 3'h7;
    localparam logic [7:0] ENH_KEY     = 8'hBF;
    localparam int         LC_DIV_BIT  = 7;
    localparam int         FCT_SWAP    = 6;
    localparam int         EF_ENH_BIT  = 4;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] IE_ENH_MASK = 8'hF0;
    localparam logic [7:0] IS_ENH_MASK = 8'h30;
    localparam logic [7:0] FC_ENH_MASK = 8'h30;
    localparam logic [7:0] MC_ENH_MASK = 8'hE0;

    typedef enum logic [2:0] {
        UCRD_NONE = 3'h0, UCRD_HOLD = 3'h1, UCRD_DIVL = 3'h2, UCRD_DIVH = 3'h3,
        UCRD_IE   = 3'h4, UCRD_ISFC = 3'h5, UCRD_TRG  = 3'h6, UCRD_OTHER = 3'h7
    } ucrd_sel_t;

    // Host access of one cycle
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ucrd_acc_t;

    // Status presented by the channel datapath
    typedef struct packed {
        logic [7:0] rx_holding;
        logic [7:0] interrupt_status;
        logic [7:0] line_status;
        logic [7:0] modem_status;
        logic [7:0] fifo_level_count;
        logic [7:0] fifo_level_alt;
    } ucrd_stat_t;

    // Configuration driven toward the channel datapath
    typedef struct packed {
        logic [7:0] divisor_low;
        logic [7:0] divisor_high;
        logic [7:0] interrupt_enable;
        logic [7:0] fifo_control;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] scratchpad;
        logic [7:0] enhanced_mode_select;
        logic [7:0] fifo_trigger_level;
        logic [7:0] feature_control;
        logic [7:0] enhanced_function;
        logic [7:0] xon_char_1;
        logic [7:0] xon_char_2;
        logic [7:0] xoff_char_1;
        logic [7:0] xoff_char_2;
    } ucrd_cfg_t;
endpackage

// File: verification/testbench.sv
// Self-checking testbench for the channel register decode block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] REV_TB   = 8'h3C;  // Arbitrary value
    localparam logic [7:0] ID_TB    = 8'hC3;  // Arbitrary value
    localparam logic [1:0] SEL_A    = 2'b10;
    localparam logic [1:0] SEL_B    = 2'b01;
    localparam logic [1:0] SEL_NONE = 2'b11;
    localparam logic [1:0] SEL_BOTH = 2'b00;
    logic                  sys_clk;
    logic                  reset;
    logic                  channel_a_select_n;
    logic                  channel_b_select_n;
    ucrd_pkg::ucrd_acc_t   acc;
    ucrd_pkg::ucrd_stat_t  stat_a;
    ucrd_pkg::ucrd_stat_t  stat_b;
    logic [7:0]            rdata;
    logic                  rdata_valid;
    ucrd_pkg::ucrd_cfg_t   cfg_a;
    ucrd_pkg::ucrd_cfg_t   cfg_b;
    ucrd_pkg::ucrd_cfg_t   snap;
    logic [1:0]            tx_holding_wr;
    logic [7:0]            tx_holding;
    logic [1:0]            rx_holding_rd;
    logic [1:0]            line_status_rd;
    logic [1:0]            modem_status_rd;
    logic [1:0]            interrupt_status_rd;
    logic [7:0]            rd_v;
    logic                  vld;
    int                    err_total;
    int                    check_count;

    ucrd_decode #(.NUM_CH(2), .REVISION_CODE(REV_TB), .DEVICE_ID(ID_TB)) dut_u (
        .sys_clk(sys_clk), .reset(reset), .channel_a_select_n(channel_a_select_n),
        .channel_b_select_n(channel_b_select_n), .acc(acc), .stat_a(stat_a), .stat_b(stat_b),
        .rdata(rdata), .rdata_valid(rdata_valid), .cfg_a(cfg_a), .cfg_b(cfg_b),
        .tx_holding_wr(tx_holding_wr), .tx_holding(tx_holding), .rx_holding_rd(rx_holding_rd),
        .line_status_rd(line_status_rd), .modem_status_rd(modem_status_rd),
        .interrupt_status_rd(interrupt_status_rd)
    );
    ucrd_host host_u (
        .sys_clk(sys_clk), .rdata(rdata), .rdata_valid(rdata_valid), .acc(acc),
        .channel_a_select_n(channel_a_select_n), .channel_b_select_n(channel_b_select_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [119:0] seen, input logic [119:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, a, d, s, rd_v, vld);
    endtask
    task automatic rd(input logic [1:0] s, input logic [2:0] a, input logic [7:0] exp);
        host_u.xfer(1'b0, a, 8'h00, s, rd_v, vld);
        chk("rdata_valid", vld, 1'b1);
        chk("rdata", rd_v, exp);
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_base();
        chk("cfg_a_reset", cfg_a, '0);
        wr(SEL_A, ucrd_pkg::ADDR_LC, 8'h03);
        rd(SEL_A, ucrd_pkg::ADDR_LC, 8'h03);
        wr(SEL_A, ucrd_pkg::ADDR_HOLD, 8'h5C);
        chk("tx_holding_wr", tx_holding_wr, 2'b01);
        chk("tx_holding", tx_holding, 8'h5C);
        rd(SEL_A, ucrd_pkg::ADDR_HOLD, 8'hA1);
        chk("rx_holding_rd", rx_holding_rd, 2'b01);
        wr(SEL_A, ucrd_pkg::ADDR_IE, 8'hFF);
        rd(SEL_A, ucrd_pkg::ADDR_IE, 8'h0F);
        rd(SEL_A, ucrd_pkg::ADDR_ISFC, 8'h0C);
        chk("interrupt_status_rd", interrupt_status_rd, 2'b01);
        wr(SEL_A, ucrd_pkg::ADDR_ISFC, 8'hFF);
        chk("fifo_control", cfg_a.fifo_control, 8'hCF);
        wr(SEL_A, ucrd_pkg::ADDR_MC, 8'hFF);
        rd(SEL_A, ucrd_pkg::ADDR_MC, 8'h1F);
        snap = cfg_a;
        wr(SEL_A, ucrd_pkg::ADDR_LS, 8'h77);
        wr(SEL_A, ucrd_pkg::ADDR_MS, 8'h77);
        chk("cfg_a_ro_write", cfg_a, snap);
        rd(SEL_A, ucrd_pkg::ADDR_LS, 8'hA3);
        chk("line_status_rd", line_status_rd, 2'b01);
        rd(SEL_A, ucrd_pkg::ADDR_MS, 8'hA4);
        chk("modem_status_rd", modem_status_rd, 2'b01);
        wr(SEL_A, ucrd_pkg::ADDR_SP, 8'h96);
        rd(SEL_A, ucrd_pkg::ADDR_SP, 8'h96);
    endtask
    task automatic t_div();
        wr(SEL_A, ucrd_pkg::ADDR_LC, 8'h83);
        rd(SEL_A, ucrd_pkg::ADDR_HOLD, REV_TB);
        chk("rx_holding_rd", rx_holding_rd, 2'b00);
        rd(SEL_A, ucrd_pkg::ADDR_IE, ID_TB);
        wr(SEL_A, ucrd_pkg::ADDR_HOLD, 8'h34);
        chk("tx_holding_wr", tx_holding_wr, 2'b00);
        wr(SEL_A, ucrd_pkg::ADDR_IE, 8'h12);
        rd(SEL_A, ucrd_pkg::ADDR_HOLD, 8'h34);
        rd(SEL_A, ucrd_pkg::ADDR_IE, 8'h12);
        chk("divisor", {cfg_a.divisor_high, cfg_a.divisor_low}, 16'h1234);
        chk("interrupt_enable", cfg_a.interrupt_enable, 8'h0F);
    endtask
    task automatic t_key();
        wr(SEL_A, ucrd_pkg::ADDR_LC, ucrd_pkg::ENH_KEY);
        wr(SEL_A, ucrd_pkg::ADDR_HOLD, 8'h21);
        chk("fifo_trigger_level", cfg_a.fifo_trigger_level, 8'h21);
        rd(SEL_A, ucrd_pkg::ADDR_HOLD, 8'hA5);
        wr(SEL_A, ucrd_pkg::ADDR_IE, 8'h40);
        rd(SEL_A, ucrd_pkg::ADDR_IE, 8'h40);
        wr(SEL_A, ucrd_pkg::ADDR_ISFC, 8'h10);
        rd(SEL_A, ucrd_pkg::ADDR_ISFC, 8'h10);
        for (int i = 0; i < 4; i++) begin
            wr(SEL_A, 3'h4 + 3'(i), 8'hE0 + 8'(i));
        end
        chk("xon_xoff", {cfg_a.xon_char_1, cfg_a.xon_char_2, cfg_a.xoff_char_1, cfg_a.xoff_char_2},
            32'hE0E1E2E3);
        rd(SEL_A, ucrd_pkg::ADDR_LC, ucrd_pkg::ENH_KEY);
        wr(SEL_A, ucrd_pkg::ADDR_LC, 8'h03);
        rd(SEL_A, ucrd_pkg::ADDR_SP, 8'hA6);
        wr(SEL_A, ucrd_pkg::ADDR_SP, 8'h5A);
        chk("enhanced_mode_select", cfg_a.enhanced_mode_select, 8'h5A);
        chk("scratchpad", cfg_a.scratchpad, 8'h96);
        wr(SEL_A, ucrd_pkg::ADDR_IE, 8'hFF);
        rd(SEL_A, ucrd_pkg::ADDR_IE, 8'hFF);
        wr(SEL_A, ucrd_pkg::ADDR_MC, 8'hFF);
        rd(SEL_A, ucrd_pkg::ADDR_MC, 8'hFF);
        rd(SEL_A, ucrd_pkg::ADDR_ISFC, 8'h3C);
    endtask
    task automatic t_chan();
        snap = cfg_a;
        wr(SEL_B, ucrd_pkg::ADDR_SP, 8'h69);
        rd(SEL_B, ucrd_pkg::ADDR_SP, 8'h69);
        chk("cfg_a_b_write", cfg_a, snap);
        rd(SEL_B, ucrd_pkg::ADDR_HOLD, 8'hB1);
        chk("rx_holding_rd_b", rx_holding_rd, 2'b10);
        host_u.xfer(1'b1, ucrd_pkg::ADDR_SP, 8'h11, SEL_NONE, rd_v, vld);
        chk("cfg_a_unsel", cfg_a, snap);
        chk("cfg_b_unsel", cfg_b.scratchpad, 8'h69);
        chk("tx_holding_unsel", tx_holding, 8'h5C);
        host_u.xfer(1'b0, ucrd_pkg::ADDR_LS, 8'h00, SEL_NONE, rd_v, vld);
        chk("rdata_valid_unsel", vld, 1'b0);
        chk("line_status_rd_unsel", line_status_rd, 2'b00);
        wr(SEL_B, ucrd_pkg::ADDR_LC, ucrd_pkg::ENH_KEY);
        wr(SEL_B, ucrd_pkg::ADDR_SP, 8'h7E);
        chk("xoff_char_2_b", {cfg_b.xoff_char_2, cfg_b.scratchpad}, 16'h7E69);
        chk("cfg_a_b_key", cfg_a, snap);
        wr(SEL_BOTH, ucrd_pkg::ADDR_LC, 8'h00);
        chk("line_control_both", {cfg_a.line_control, cfg_b.line_control}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Bounded run: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        summarize();
    end
    initial begin
        err_total = 0;
        check_count = 0;
        reset = 1'b1;
        stat_a = {8'hA1, 8'h3C, 8'hA3, 8'hA4, 8'hA5, 8'hA6};
        stat_b = {8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6};
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_base();
        t_div();
        t_key();
        t_chan();
        summarize();
    end
endmodule // testbench
`default_nettype wire

// File: verification/ucrd_host.sv
// Host processor model driving the channel register bus
`timescale 1ns/1ns
`default_nettype none
module ucrd_host (
    input  wire logic           sys_clk,
    input  wire logic [7:0]     rdata,
    input  wire logic           rdata_valid,
    output ucrd_pkg::ucrd_acc_t acc,
    output logic                channel_a_select_n,
    output logic                channel_b_select_n
);
    initial begin
        acc = '0;
        channel_a_select_n = 1'b1;
        channel_b_select_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One access per call; sel_n is {channel B, channel A}, active low
    task automatic xfer(input logic wr, input logic [2:0] addr, input logic [7:0] wdata,
                        input logic [1:0] sel_n, output logic [7:0] data, output logic valid);
        @(posedge sys_clk);
        acc <= '{rd: ~wr, wr: wr, addr: addr, wdata: wdata};
        {channel_b_select_n, channel_a_select_n} <= sel_n;
        @(posedge sys_clk);
        // Released bus shows inverted leftovers so a stale value never looks valid
        acc <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        {channel_b_select_n, channel_a_select_n} <= 2'b11;
        #1;
        data = rdata;
        valid = rdata_valid;
    endtask
endmodule // ucrd_host
`default_nettype wire
